// [src/pmtr_core.sv]
// Program store, reset vector, table read and serial programming unit.
`timescale 1ns/10ps
`default_nettype none
`include "pmtr_consts.svh"
module pmtr_core
  import pmtr_pkg::*;
#(
  parameter int WORDS  = `PMTR_WORDS,
  parameter int ADDR_W = `PMTR_ADDR_W
) (
  // System.
  input  wire logic              clock,
  input  wire logic              rstn,
  // Instruction fetch.
  input  wire logic              pc_advance,
  input  wire logic              pc_load,
  input  wire logic [ADDR_W-1:0] pc_target,
  output logic [ADDR_W-1:0]      program_counter,
  output logic [`PMTR_WORD_W-1:0] instruction,
  // Table read request.
  input  wire logic              table_start,
  input  wire logic              table_last_page,
  input  wire logic [7:0]        table_ptr_low,
  input  wire logic [2:0]        table_ptr_high,
  input  wire logic [7:0]        table_dest,
  output logic                   table_busy,
  output logic                   table_done,
  output logic                   data_write,
  output logic [7:0]             data_addr,
  output logic [7:0]             data_value,
  output logic [7:0]             table_high_latch,
  // Programming and debug link.
  input  wire logic              link_clock,
  input  wire logic              link_rstn,
  input  wire logic              debug_mode,
  input  wire logic              prog_serial_data_line_in,
  output logic                   prog_serial_data_line_out,
  output logic                   prog_serial_data_line_oe,
  input  wire logic              debug_data_line_in,
  output logic                   debug_data_line_out,
  output logic                   debug_data_line_oe,
  output logic                   link_write_done
);
  // ==========================================================
  // Program store.
  logic [`PMTR_WORD_W-1:0] store [WORDS];
  logic [ADDR_W-1:0]       table_addr;
  logic [`PMTR_WORD_W-1:0] table_word;
  pmtr_state_t             state;

  // ==========================================================
  // Program counter and fetch.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      program_counter <= `PMTR_RESET_VECTOR;
    end else if (pc_load) begin
      program_counter <= pc_target;
    end else if (pc_advance) begin
      program_counter <= program_counter + ADDR_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      instruction <= '0;
    end else begin
      instruction <= store[program_counter];
    end
  end

  // ==========================================================
  // Table read sequencer: request cycle, fetch, store.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state      <= PMTR_IDLE;
      table_addr <= '0;
    end else begin
      case (state)
        PMTR_IDLE: begin
          if (table_start) begin
            state <= PMTR_FETCH;
            if (table_last_page) begin
              table_addr <= {`PMTR_LAST_PAGE, table_ptr_low};
            end else begin
              table_addr <= {table_ptr_high, table_ptr_low};
            end
          end
        end
        PMTR_FETCH: begin
          state <= PMTR_STORE;
        end
        PMTR_STORE: begin
          state <= PMTR_IDLE;
        end
        default: begin
          state <= PMTR_IDLE;
        end
      endcase
    end
  end

  assign table_busy = (state != PMTR_IDLE);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      table_word <= '0;
    end else if (state == PMTR_FETCH) begin
      table_word <= store[table_addr];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_addr  <= 8'h00;
      data_value <= 8'h00;
      data_write <= 1'b0;
      table_done <= 1'b0;
    end else begin
      data_write <= (state == PMTR_STORE);
      table_done <= (state == PMTR_STORE);
      if (state == PMTR_STORE) begin
        data_addr  <= table_dest;
        data_value <= table_word[7:0];
      end
    end
  end

  // Software has no write path to the latch.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      table_high_latch <= 8'h00;
    end else if (state == PMTR_STORE) begin
      table_high_latch <= {1'b0, table_word[`PMTR_HIGH_MSB:`PMTR_HIGH_LSB]};
    end
  end

  // ==========================================================
  // Serial link: debug pins double as programming pins.
  logic                    link_data_in;
  logic                    link_data_out;
  logic                    link_data_oe;
  logic [`PMTR_SER_FRAME_W-1:0] frame;
  logic                    frame_toggle;
  logic [`PMTR_WORD_W-1:0] read_word;

  assign link_data_in = debug_mode ? debug_data_line_in : prog_serial_data_line_in;
  assign prog_serial_data_line_out = link_data_out;
  assign prog_serial_data_line_oe  = link_data_oe & ~debug_mode;
  assign debug_data_line_out       = link_data_out;
  assign debug_data_line_oe        = link_data_oe & debug_mode;

  pmtr_serial_port #(
    .FRAME_W (`PMTR_SER_FRAME_W)
  ) u_port (
    .link_clock   (link_clock),
    .link_rstn    (link_rstn),
    .data_in      (link_data_in),
    .data_out     (link_data_out),
    .data_oe      (link_data_oe),
    .frame        (frame),
    .frame_toggle (frame_toggle),
    .read_word    (read_word)
  );

  // Frame toggle crosses with two flip-flops; frame is stable by then.
  logic       tog_meta;
  logic       tog_sync;
  logic       tog_seen;
  logic [`PMTR_SER_FRAME_W-1:0] frame_hold;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
    end else begin
      tog_meta <= frame_toggle;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      frame_hold <= '0;
    end else if (tog_sync != tog_seen) begin
      frame_hold <= frame;
    end
  end

  // Writes land in the store; the word at the last frame's address is registered every cycle for the link.
  logic write_event;
  assign write_event = (tog_sync != tog_seen) &&
                       (frame[31:28] == `PMTR_CMD_WRITE);

  always_ff @(posedge clock) begin
    if (write_event) begin
      store[frame[26:16]] <= frame[14:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_write_done <= 1'b0;
    end else begin
      link_write_done <= write_event;
    end
  end

  // Read word is sampled by the link side only after a read frame.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      read_word <= '0;
    end else begin
      read_word <= store[frame_hold[26:16]];
    end
  end

  // ==========================================================
  // Checks.
  reset_vector_a: assert property (@(posedge clock)
    $rose(rstn) |-> program_counter == 11'h000)
    else $error("Program counter not at reset vector.");
  two_cycle_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == PMTR_IDLE && table_start) |=> table_busy ##1 table_busy ##1 table_done)
    else $error("Table read did not take two cycles.");
  last_page_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == PMTR_IDLE && table_start && table_last_page) |=> table_addr[10:8] == 3'h7)
    else $error("Last page address wrong.");
  pointer_join_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == PMTR_IDLE && table_start && !table_last_page)
      |=> table_addr == {$past(table_ptr_high), $past(table_ptr_low)})
    else $error("Table address not formed from pointers.");
  low_byte_a: assert property (@(posedge clock) disable iff (!rstn)
    data_write |-> data_value == table_word[7:0])
    else $error("Low byte not written.");
  latch_update_a: assert property (@(posedge clock) disable iff (!rstn)
    table_done |-> table_high_latch[6:0] == table_word[14:8])
    else $error("Latch missed high part.");
  latch_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    ($past(state) != PMTR_STORE) |-> $stable(table_high_latch))
    else $error("Latch changed without a table read.");
  latch_top_a: assert property (@(posedge clock) disable iff (!rstn)
    table_high_latch[7] == 1'b0)
    else $error("Latch top bit not zero.");
  pin_select_a: assert property (@(posedge clock) disable iff (!rstn)
    !(prog_serial_data_line_oe && debug_data_line_oe))
    else $error("Both data lines driven.");

  // Fetch checks.
  pc_load_a: assert property (@(posedge clock) disable iff (!rstn)
    pc_load |=> program_counter == $past(pc_target))
    else $error("Program counter missed a load.");
  pc_step_a: assert property (@(posedge clock) disable iff (!rstn)
    (pc_advance && !pc_load) |=> program_counter == ADDR_W'($past(program_counter) + 1'b1))
    else $error("Program counter missed a step.");

  // Table read checks.
  last_low_a: assert property (@(posedge clock) disable iff (!rstn)
    (state == PMTR_IDLE && table_start && table_last_page) |=> table_addr[7:0] == $past(table_ptr_low))
    else $error("Last page low part wrong.");
  dest_addr_a: assert property (@(posedge clock) disable iff (!rstn)
    data_write |-> data_addr == $past(table_dest))
    else $error("Low byte sent to wrong register.");
  done_data_a: assert property (@(posedge clock) disable iff (!rstn)
    table_done |-> data_write)
    else $error("Table read ended without a write.");
  done_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
    table_done |=> !table_done)
    else $error("Table done held too long.");
  busy_ends_a: assert property (@(posedge clock) disable iff (!rstn)
    table_done |-> !table_busy)
    else $error("Table still busy when done.");
  start_refused_a: assert property (@(posedge clock) disable iff (!rstn)
    (table_busy && table_start) |=> $stable(table_addr))
    else $error("Request taken while busy.");
  latch_busy_a: assert property (@(posedge clock) disable iff (!rstn)
    table_busy |-> $stable(table_high_latch))
    else $error("Latch changed during a table read.");

  // Link checks.
  write_lands_a: assert property (@(posedge clock) disable iff (!rstn)
    link_write_done |-> store[frame_hold[26:16]] == frame_hold[14:0])
    else $error("Link write did not land.");
  debug_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    !debug_mode |-> !debug_data_line_oe)
    else $error("Debug line driven outside debug mode.");
  prog_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    debug_mode |-> !prog_serial_data_line_oe)
    else $error("Programming line driven in debug mode.");
endmodule
`default_nettype wire

// [src/pmtr_consts.svh]
// Constants of the program memory table read unit.
`ifndef PMTR_CONSTS_SVH
`define PMTR_CONSTS_SVH
`define PMTR_WORDS        2048
`define PMTR_WORD_W       15
`define PMTR_ADDR_W       11
`define PMTR_RESET_VECTOR 11'h000
`define PMTR_LAST_PAGE    3'h7
`define PMTR_HIGH_MSB     14
`define PMTR_HIGH_LSB     8
`define PMTR_SER_CMD_W    4
`define PMTR_SER_FRAME_W  32
`define PMTR_CMD_WRITE    4'h1
`define PMTR_CMD_READ     4'h2
`endif

// [src/pmtr_pkg.sv]
// Types of the program memory table read unit.
package pmtr_pkg;
  typedef enum logic [2:0] {
    PMTR_IDLE  = 3'b001,
    PMTR_FETCH = 3'b010,
    PMTR_STORE = 3'b100
  } pmtr_state_t;
endpackage

// [src/pmtr_serial_port.sv]
// Serial programming and debug link shifter on the link clock.
`timescale 1ns/10ps
`default_nettype none
`include "pmtr_consts.svh"
module pmtr_serial_port #(
  parameter int FRAME_W = `PMTR_SER_FRAME_W
) (
  // Link side.
  input  wire logic                      link_clock,
  input  wire logic                      link_rstn,
  input  wire logic                      data_in,
  output logic                           data_out,
  output logic                           data_oe,
  // Frame results, held until the next frame.
  output logic [FRAME_W-1:0]             frame,
  output logic                           frame_toggle,
  // Read back data from the core side, already stable.
  input  wire logic [`PMTR_WORD_W-1:0]   read_word
);
  // ==========================================================
  // Shift in command, address, data; shift out on read.
  logic [5:0]         count;
  logic [FRAME_W-1:0] shift;
  logic [`PMTR_WORD_W-1:0] out_shift;
  logic               reading;

  always_ff @(posedge link_clock or negedge link_rstn) begin
    if (!link_rstn) begin
      count        <= 6'h00;
      shift        <= '0;
      frame        <= '0;
      frame_toggle <= 1'b0;
    end else if (reading) begin
      if (count == 6'(`PMTR_WORD_W)) begin
        count <= 6'h00;
      end else begin
        count <= count + 6'h01;
      end
    end else begin
      shift <= {shift[FRAME_W-2:0], data_in};
      if (count == 6'(FRAME_W - 1)) begin
        count        <= 6'h00;
        frame        <= {shift[FRAME_W-2:0], data_in};
        frame_toggle <= ~frame_toggle;
      end else begin
        count <= count + 6'h01;
      end
    end
  end

  // A read frame turns the line round and returns one word.
  always_ff @(posedge link_clock or negedge link_rstn) begin
    if (!link_rstn) begin
      reading   <= 1'b0;
      out_shift <= '0;
      data_out  <= 1'b0;
      data_oe   <= 1'b0;
    end else if (reading) begin
      data_out  <= out_shift[`PMTR_WORD_W-1];
      out_shift <= {out_shift[`PMTR_WORD_W-2:0], 1'b0};
      data_oe   <= 1'b1;
      if (count == 6'(`PMTR_WORD_W)) begin
        reading <= 1'b0;
        data_oe <= 1'b0;
      end
    end else if (count == 6'(FRAME_W - 1) &&
                 shift[FRAME_W-2 -: `PMTR_SER_CMD_W] == `PMTR_CMD_READ) begin
      reading   <= 1'b1;
      out_shift <= read_word;
    end
  end
endmodule
`default_nettype wire

// [tb/pmtr_writer.sv]
// Writer and debug adapter model on the far side of the link.
`timescale 1ns/10ps
`default_nettype none
module pmtr_writer (
  // Link pins.
  output logic      sck,
  output logic      sdo,
  output logic      soe,
  input  wire logic sdi,
  input  wire logic dev_oe
);
  initial begin
    sck = 1'b0;
    sdo = 1'b0;
    soe = 1'b0;
  end
  // Shifts one frame out MSB first; the clock stands still between frames.
  task automatic send(input logic [31:0] f, input logic release_after);
    for (int i = 31; i >= 0; i--) begin
      sdo = f[i];
      soe = 1'b1;
      #15 sck = 1'b1;
      #15 sck = 1'b0;
    end
    if (release_after) begin
      soe = 1'b0;
    end
  endtask
  // Gives one clock per answer bit and one more to turn the line round.
  task automatic receive(output logic [14:0] w, output int n);
    w = '0;
    n = 0;
    repeat (16) begin
      #15 sck = 1'b1;
      #7;
      if (dev_oe === 1'b1) begin
        w = {w[13:0], sdi};
        n++;
      end
      #8 sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the program memory table read unit.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pmtr_pkg::*;
  logic        clock, rstn, pc_advance, pc_load, table_start, table_last_page, debug_mode, idle;
  logic        table_busy, table_done, data_write, link_write_done;
  logic        pd_out, pd_oe, dd_out, dd_oe, w_do, w_oe, sck, line, dev_oe, dev_out, pin, din;
  logic [10:0] pc_target, program_counter;
  logic [14:0] instruction;
  logic [14:0] mem [0:2047];
  logic [7:0]  table_ptr_low, table_dest, data_addr, data_value, table_high_latch;
  logic [2:0]  table_ptr_high;
  int          num_errors, samples_checked, cycles;
  // A released line shows a pattern that changes every cycle.
  assign dev_oe  = debug_mode ? dd_oe : pd_oe;
  assign dev_out = debug_mode ? dd_out : pd_out;
  assign line    = dev_oe ? dev_out : (w_oe ? w_do : idle);
  assign pin     = debug_mode ? idle : line;
  assign din     = debug_mode ? line : idle;
  pmtr_writer wr (.sck(sck), .sdo(w_do), .soe(w_oe), .sdi(line), .dev_oe(dev_oe));
  pmtr_core dut (.clock, .rstn, .pc_advance, .pc_load, .pc_target, .program_counter, .instruction,
    .table_start, .table_last_page, .table_ptr_low, .table_ptr_high, .table_dest, .table_busy,
    .table_done, .data_write, .data_addr, .data_value, .table_high_latch, .link_clock(sck),
    .link_rstn(rstn), .debug_mode, .prog_serial_data_line_in(pin), .prog_serial_data_line_out(pd_out),
    .prog_serial_data_line_oe(pd_oe), .debug_data_line_in(din), .debug_data_line_out(dd_out),
    .debug_data_line_oe(dd_oe), .link_write_done);
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    idle <= ~idle;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ==========================================================
  // Shared tasks.
  task automatic cmp(input logic [15:0] a, input logic [15:0] e);
    samples_checked++;
    if (a !== e) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic lwrite(input logic md, input logic [10:0] a, input logic [14:0] d);
    int n;
    step();
    debug_mode = md;
    wr.send({4'h1, 1'b0, a, 1'b0, d}, 1'b1);
    n = 0;
    while (link_write_done !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    cmp(16'(n < 40), 16'h1);
    mem[a] = d;
  endtask
  task automatic lread(input logic md, input logic [10:0] a);
    logic [14:0] w;
    int          n;
    step();
    debug_mode = md;
    wr.send({4'h0, 1'b0, a, 16'h0}, 1'b0);
    wr.send({4'h2, 1'b0, a, 16'h0}, 1'b1);
    wr.receive(w, n);
    cmp(16'(n), 16'h000f);
    cmp(16'(w), 16'(mem[a]));
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_link();
    lwrite(1'b0, 11'h706, 15'h7a5a);
    lwrite(1'b1, 11'h705, 15'h0123);
    lwrite(1'b0, 11'h1a3, 15'h5f81);
    lwrite(1'b1, 11'h000, 15'h2c3e);
    lread(1'b0, 11'h706);
    lread(1'b1, 11'h705);
    $display("test link done");
  endtask
  // Only this bench requests table reads, so the latch is never shared.
  task automatic t_table(input logic lp, input logic [2:0] hi, input logic [7:0] lo, input logic [7:0] dst,
                         input logic [10:0] a);
    int n;
    table_last_page = lp;
    table_ptr_high = hi;
    table_ptr_low = lo;
    table_dest = dst;
    table_start = 1'b1;
    step();
    cmp(16'(table_busy), 16'h1);
    table_ptr_low = ~lo;
    table_ptr_high = ~hi;
    step();
    table_start = 1'b0;
    n = 2;
    while (table_done !== 1'b1 && n < 8) begin
      step();
      n++;
    end
    cmp(16'(n), 16'h0003);
    cmp(16'(data_write), 16'h1);
    cmp(16'(data_addr), 16'(dst));
    cmp(16'(data_value), 16'(mem[a][7:0]));
    cmp(16'(table_high_latch), 16'({1'b0, mem[a][14:8]}));
    cmp(16'(table_busy), 16'h0);
    $display("test table read done");
  endtask
  task automatic t_fetch();
    step();
    pc_load = 1'b1;
    pc_target = 11'h705;
    step();
    pc_load = 1'b0;
    pc_advance = 1'b1;
    cmp(16'(program_counter), 16'h0705);
    step();
    pc_advance = 1'b0;
    cmp(16'(program_counter), 16'h0706);
    cmp(16'(instruction), 16'(mem[11'h705]));
    step();
    cmp(16'(instruction), 16'(mem[11'h706]));
    cmp(16'(table_high_latch), 16'({1'b0, mem[11'h705][14:8]}));
    $display("test fetch done");
  endtask
  task automatic t_reset();
    rstn = 1'b0;
    step();
    step();
    cmp(16'(program_counter), 16'h0000);
    cmp(16'(table_high_latch), 16'h0000);
    rstn = 1'b1;
    step();
    step();
    cmp(16'(program_counter), 16'h0000);
    cmp(16'(instruction), 16'(mem[11'h000]));
    $display("test reset done");
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {clock, rstn, pc_advance, pc_load, table_start, table_last_page, debug_mode, idle} = '0;
    {pc_target, table_ptr_low, table_ptr_high, table_dest} = '0;
    {num_errors, samples_checked, cycles} = '0;
    repeat (4) @(posedge clock);
    #1 rstn = 1'b1;
    t_link();
    t_table(1'b0, 3'h1, 8'ha3, 8'h42, 11'h1a3);
    t_table(1'b1, 3'h2, 8'h06, 8'h10, 11'h706);
    t_table(1'b1, 3'h0, 8'h05, 8'h11, 11'h705);
    t_fetch();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
